// ===== sah_handshake.sv
// Serial port handshake: ready routing, data-first reads, CRC, power, reset
`timescale 1ns/1ps
`default_nettype none

module sah_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sah_fptr_t;
  sah_fptr_t ptr_reg, ptr_next;
  logic [W-1:0] mem [D];
  logic full, empty;

  assign empty = ptr_reg.wp == ptr_reg.rp;
  assign full = ptr_reg.wp == {~ptr_reg.rp[AW], ptr_reg.rp[AW-1:0]};
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[ptr_reg.rp[AW-1:0]];

  always_comb begin
    ptr_next = ptr_reg;
    if (in_valid && !full) ptr_next.wp = ptr_reg.wp + 1'b1;
    if (out_ready && !empty) ptr_next.rp = ptr_reg.rp + 1'b1;
    if (flush) ptr_next = '0;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) ptr_reg <= '0;
    else ptr_reg <= ptr_next;
    if (in_valid && !full) mem[ptr_reg.wp[AW-1:0]] <= in_data;
  end
endmodule : sah_fifo

module sah_handshake (
  input wire logic core_clk,
  input wire logic nrst,
  input wire sah_pkg::sah_cfg_t cfg,
  input wire logic sclk_in,
  input wire logic chip_select_n,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe,
  output logic gpio_pin_six_out,
  output logic gpio_pin_six_oe,
  input wire logic ready_raw_n,
  output logic data_ready_n,
  output logic [6:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic ext_bit_valid,
  input wire logic ext_bit,
  input wire logic ext_bit_is_crc,
  input wire logic checksum_read_done,
  output logic [7:0] checksum_value,
  output logic data_first_mode,
  input wire logic pwr_wr,
  input wire logic [1:0] pwr_req,
  output logic [1:0] power_state,
  output logic conv_enable,
  input wire logic key_wr,
  input wire logic [7:0] soft_reset_key,
  input wire logic restart_wr,
  output logic reg_reset_pulse,
  output logic cal_reset_pulse,
  output logic conv_restart
);
  typedef struct packed {
    logic sclk_s1, sclk_s2, sclk_d;
    logic csn_s1, csn_s2, csn_d;
    logic sdi_s1, sdi_s2;
    logic rdy_d;
    sah_pkg::sah_ph_t ph;
    logic [7:0] rx;
    logic [2:0] rx_cnt;
    logic [7:0] tx;
    logic [2:0] tx_cnt;
    logic loaded;
    logic [2:0] left;
    logic [6:0] fetch_addr;
    logic [3:0] fetch_left;
    logic df;
    logic [7:0] crc;
    logic rel_force;
    sah_pkg::sah_pwr_t pwr_target;
    sah_pkg::sah_pwr_t pwr_shown;
    logic [8:0] pwr_busy;
    logic key_armed;
    logic reg_rst;
    logic cal_rst;
    logic restart;
  } sah_state_t;

  localparam logic [8:0] LAT = 9'(sah_pkg::PWR_LAT_CYC);
  sah_state_t q_reg, q_next;
  logic rise, csn_fall, csn_rise, sending, ready_n, rx_done;
  logic [7:0] rx_byte;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, pop;
  logic [7:0] fifo_out_data;

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[7] ^ b;
    crc_step = {c[6:0], 1'b0} ^ (fb ? sah_pkg::CRC_POLY : 8'h00); // RULE_14
  endfunction : crc_step

  assign rise = q_reg.sclk_s2 && !q_reg.sclk_d;
  assign csn_fall = !q_reg.csn_s2 && q_reg.csn_d;
  assign csn_rise = q_reg.csn_s2 && !q_reg.csn_d;
  assign sending = q_reg.ph == sah_pkg::ST_SEND && q_reg.loaded;
  assign ready_n = ready_raw_n || q_reg.rel_force; // RULE_16
  assign rx_byte = {q_reg.rx[6:0], q_reg.sdi_s2};
  assign rx_done = q_reg.ph == sah_pkg::ST_CMD && rise && q_reg.rx_cnt == 3'h7;
  assign pop = q_reg.ph == sah_pkg::ST_SEND && !q_reg.loaded && fifo_out_valid;
  // Fetch pauses while the FIFO is full; no separate upper page is touched
  assign fifo_in_valid = q_reg.ph == sah_pkg::ST_SEND && q_reg.fetch_left != 0; // RULE_10

  sah_fifo #(.W(sah_pkg::FIFO_W), .D(sah_pkg::FIFO_D)) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .flush(csn_rise),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(rd_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  always_comb begin
    logic [7:0] crc_base;
    logic clr;
    crc_base = '0;
    clr = 1'b0;
    q_next = q_reg;
    q_next.sclk_s1 = sclk_in;
    q_next.sclk_s2 = q_reg.sclk_s1;
    q_next.sclk_d = q_reg.sclk_s2;
    q_next.csn_s1 = chip_select_n;
    q_next.csn_s2 = q_reg.csn_s1;
    q_next.csn_d = q_reg.csn_s2;
    q_next.sdi_s1 = sdi_in;
    q_next.sdi_s2 = q_reg.sdi_s1;
    q_next.rdy_d = ready_n;
    q_next.reg_rst = 1'b0;
    q_next.cal_rst = 1'b0;
    q_next.restart = restart_wr; // RULE_22

    // CRC clear and accumulation; an arriving bit is kept over a clear
    clr = csn_rise || (ready_n && !q_reg.rdy_d && !cfg.checksum_hold_over); // RULE_13 RULE_17
    crc_base = clr ? sah_pkg::CRC_INIT : q_reg.crc;
    if (cfg.checksum_enable && sending && rise) begin
      crc_base = crc_step(crc_base, q_reg.tx[7]); // RULE_12
    end else if (cfg.checksum_enable && ext_bit_valid && !ext_bit_is_crc) begin
      crc_base = crc_step(crc_base, ext_bit); // RULE_15
    end
    q_next.crc = crc_base;

    if (checksum_read_done && cfg.ready_release_after_checksum && !ready_raw_n)
      q_next.rel_force = 1'b1; // RULE_16
    else if (ready_raw_n) q_next.rel_force = 1'b0;

    if (q_reg.ph == sah_pkg::ST_SEND && fifo_in_valid && fifo_in_ready) begin
      q_next.fetch_addr = q_reg.fetch_addr + 7'h01;
      q_next.fetch_left = q_reg.fetch_left - 4'h1;
    end

    case (q_reg.ph)
      sah_pkg::ST_IDLE: begin
        if (csn_fall && q_reg.df) begin
          q_next.ph = sah_pkg::ST_SEND; // RULE_07
          q_next.loaded = 1'b0;
          q_next.left = cfg.data_only_byte_count; // RULE_09
          q_next.fetch_addr = cfg.data_only_start_addr;
          q_next.fetch_left = {1'b0, cfg.data_only_byte_count} + 4'h1;
        end else if (csn_fall) begin
          q_next.ph = sah_pkg::ST_CMD;
          q_next.rx_cnt = '0;
        end
      end
      sah_pkg::ST_CMD: begin
        if (rise) begin
          q_next.rx = rx_byte;
          q_next.rx_cnt = q_reg.rx_cnt + 3'h1;
        end
        if (rx_done) begin
          // Other instructions belong to the register engine; stay passive
          q_next.ph = sah_pkg::ST_IDLE;
          if (rx_byte == sah_pkg::INST_DF_ON) q_next.df = 1'b1; // RULE_05
          if (rx_byte == sah_pkg::INST_DF_OFF) q_next.df = 1'b0; // RULE_05
          if (rx_byte == sah_pkg::INST_MODE_RD) begin
            q_next.ph = sah_pkg::ST_SEND;
            q_next.tx = '0;
            q_next.tx[sah_pkg::MODE_BIT] = q_reg.df; // RULE_06
            q_next.tx_cnt = '0;
            q_next.loaded = 1'b1;
            q_next.left = '0;
            q_next.fetch_left = '0;
          end
        end
      end
      sah_pkg::ST_SEND: begin
        if (pop) begin
          q_next.tx = fifo_out_data;
          q_next.tx_cnt = '0;
          q_next.loaded = 1'b1;
        end else if (sending && rise) begin
          q_next.tx = {q_reg.tx[6:0], 1'b0};
          q_next.tx_cnt = q_reg.tx_cnt + 3'h1;
          if (q_reg.tx_cnt == 3'h7) begin
            q_next.loaded = 1'b0;
            q_next.left = q_reg.left - 3'h1;
            if (q_reg.left == 3'h0) begin
              q_next.ph = sah_pkg::ST_CMD; // RULE_08
              q_next.rx_cnt = '0;
            end
          end
        end
      end
      default: q_next.ph = sah_pkg::ST_IDLE;
    endcase
    if (csn_rise) begin
      q_next.ph = sah_pkg::ST_IDLE;
      q_next.loaded = 1'b0;
      q_next.fetch_left = '0;
    end

    // Power state: the shown value lags the target by the settle time
    if (q_reg.pwr_busy != 0) begin
      q_next.pwr_busy = q_reg.pwr_busy - 9'h001;
      if (q_reg.pwr_busy == 9'h001) q_next.pwr_shown = q_reg.pwr_target; // RULE_19
    end else if (pwr_wr && pwr_req != 2'b10 && !(q_reg.pwr_target ==
        sah_pkg::PWR_DOWN && pwr_req == sah_pkg::PWR_STANDBY)) begin // RULE_20
      q_next.pwr_target = sah_pkg::sah_pwr_t'(pwr_req); // RULE_18
      q_next.pwr_busy = LAT;
    end

    if (key_wr && soft_reset_key == sah_pkg::RESET_KEY) begin
      if (cfg.cal_mode_active && !q_reg.key_armed) begin
        q_next.key_armed = 1'b1; // RULE_21
      end else begin
        q_next.key_armed = 1'b0;
        q_next.reg_rst = 1'b1; // RULE_21
        q_next.cal_rst = cfg.clear_cal_coeffs;
        q_next.restart = 1'b1; // RULE_22
        q_next.df = 1'b0;
        if (q_reg.pwr_target == sah_pkg::PWR_DOWN) begin
          q_next.pwr_target = sah_pkg::PWR_ACTIVE; // RULE_22
          q_next.pwr_busy = LAT;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      q_reg <= '0;
      q_reg.sclk_s1 <= 1'b1;
      q_reg.sclk_s2 <= 1'b1;
      q_reg.sclk_d <= 1'b1;
      q_reg.csn_s1 <= 1'b1;
      q_reg.csn_s2 <= 1'b1;
      q_reg.csn_d <= 1'b1;
      q_reg.rdy_d <= 1'b1;
      q_reg.left <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  // Ready may keep the pin while deselected; only safe with one slave
  always_comb begin
    gpio_pin_six_out = ready_n;
    gpio_pin_six_oe = 1'b0;
    sdo_out = sending ? q_reg.tx[7] : ready_n;
    sdo_oe = !q_reg.csn_s2;
    if (cfg.pin_driver_select == sah_pkg::PDS_CSB_FREE) begin
      sdo_oe = 1'b1; // RULE_01 RULE_02
    end else if (cfg.pin_driver_select == sah_pkg::PDS_GPIO6 &&
        cfg.ready_to_gpio6) begin
      gpio_pin_six_oe = 1'b1; // RULE_03
      sdo_oe = sending && !q_reg.csn_s2;
    end
  end

  assign data_ready_n = ready_n;
  assign rd_addr = q_reg.fetch_addr;
  assign checksum_value = ~q_reg.crc; // RULE_14
  assign data_first_mode = q_reg.df;
  assign power_state = q_reg.pwr_shown;
  assign conv_enable = q_reg.pwr_target == sah_pkg::PWR_ACTIVE;
  assign reg_reset_pulse = q_reg.reg_rst;
  assign cal_reset_pulse = q_reg.cal_rst;
  assign conv_restart = q_reg.restart;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  csb_free_pin_a: assert property ( // RULE_01
    cfg.pin_driver_select == sah_pkg::PDS_CSB_FREE && !sending
    |-> sdo_oe && sdo_out == data_ready_n)
    else $error("ready not driven on shared pin");
  gpio_route_a: assert property ( // RULE_03
    cfg.pin_driver_select == sah_pkg::PDS_GPIO6 && cfg.ready_to_gpio6
    |-> gpio_pin_six_oe && gpio_pin_six_out == data_ready_n && !(sdo_oe && !sending))
    else $error("ready not routed to gpio six");
  df_enter_a: assert property ( // RULE_05
    rx_done && rx_byte == sah_pkg::INST_DF_ON && !csn_rise |=> data_first_mode)
    else $error("data-first mode not entered");
  mode_status_a: assert property ( // RULE_06
    rx_done && rx_byte == sah_pkg::INST_MODE_RD && !csn_rise
    |=> q_reg.ph == sah_pkg::ST_SEND && q_reg.tx == {6'h00, $past(q_reg.df), 1'b0})
    else $error("mode status byte wrong");
  df_start_a: assert property ( // RULE_07
    q_reg.ph == sah_pkg::ST_IDLE && csn_fall && q_reg.df
    |=> q_reg.ph == sah_pkg::ST_SEND && rd_addr == $past(cfg.data_only_start_addr))
    else $error("data-only read did not start");
  crc_clear_a: assert property ( // RULE_13
    csn_rise && !ext_bit_valid && !rise |=> checksum_value == 8'hff)
    else $error("crc not cleared on deselect");
  early_release_a: assert property ( // RULE_16
    checksum_read_done && cfg.ready_release_after_checksum && !ready_raw_n
    |=> data_ready_n)
    else $error("ready not released after checksum");
  pwr_no_pd_sb_a: assert property ( // RULE_20
    q_reg.pwr_target == sah_pkg::PWR_DOWN
    |=> q_reg.pwr_target != sah_pkg::PWR_STANDBY)
    else $error("power-down went straight to standby");
  pwr_latency_a: assert property ( // RULE_19
    $changed(q_reg.pwr_target) |=> $stable(power_state) [*8])
    else $error("power state shown too early");
  reset_key_a: assert property ( // RULE_21
    key_wr && soft_reset_key == sah_pkg::RESET_KEY && !cfg.cal_mode_active
    |=> reg_reset_pulse && conv_restart && !data_first_mode)
    else $error("key write did not reset");

  df_read_c: cover property (csn_fall && q_reg.df ##[1:400] csn_rise);
  mode_read_c: cover property (rx_done && rx_byte == sah_pkg::INST_MODE_RD);
  pwr_move_c: cover property ($changed(power_state));
  double_key_c: cover property (q_reg.key_armed ##[1:50] reg_reset_pulse);
endmodule : sah_handshake
`default_nettype wire

// ===== sah_master.sv
// Serial bus master model facing the handshake block's link pins
`timescale 1ns/1ps
`default_nettype none
module sah_master (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  localparam int HALF_NS = 200;

  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // Clock parked high before select falls
  task automatic open_frame();
    #(HALF_NS);
    sclk = 1'b1;
    cs_n = 1'b0;
    #(4 * HALF_NS);
  endtask : open_frame

  task automatic close_frame();
    #(HALF_NS);
    cs_n = 1'b1;
    // Released data line must not keep its last level
    sdi = ~sdi;
    #(4 * HALF_NS);
  endtask : close_frame

  // MSB first; both sides sample on the rising edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      sdi = tx[i];
      #(HALF_NS);
      sclk = 1'b1;
      rx[i] = sdo;
      #(HALF_NS);
    end
  endtask : xfer
endmodule : sah_master
`default_nettype wire

// ===== sah_pkg.sv
// Constants and types for the serial handshake block
//
// Contract
// [RULE_01] Selector 0x03 drives ready on SDO pin regardless of chip select.
// [RULE_02] Host uses chip-select-free ready only as the sole bus slave.
// [RULE_03] Gpio route bit plus selector 0x4 puts ready on GPIO pin six.
// [RULE_04] Master asserts chip select after ready, then sends instruction bytes.
// [RULE_05] Instruction 0xFA enters data-first mode, 0xFB leaves; no data bytes.
// [RULE_06] Instruction 0x9F returns one byte, bit 1 showing data-first mode.
// [RULE_07] In data-first mode data shifts out right after chip select asserts.
// [RULE_08] After data-only bytes the device accepts normal instructions again.
// [RULE_09] Data-only read sends up to eight bytes from programmed start address.
// [RULE_10] Data-only read leaves the stored upper address page untouched.
// [RULE_11] Master parks SCLK high and finishes before next ready release.
// [RULE_12] With checksum enabled a CRC runs over read-out bits.
// [RULE_13] CRC clears when chip select or ready deasserts.
// [RULE_14] CRC x^8+x^5+x^4+1 from zero, sent ones-complemented.
// [RULE_15] CRC excludes the checksum bits themselves.
// [RULE_16] Optional ready release after checksum read, never later than normal.
// [RULE_17] Hold-over bit skips the CRC clear at regular ready deassertion.
// [RULE_18] Power write selects active, down or standby; read shows state.
// [RULE_19] Reported state follows after 15 us; earlier requests rejected.
// [RULE_20] No direct move from power-down to standby.
// [RULE_21] Key 0xC3 resets registers; calibration mode needs two writes.
// [RULE_22] Register reset restarts conversion, leaves power-down; restart bit too.
package sah_pkg;
  localparam logic [2:0] PDS_CSB_FREE = 3'h3;
  localparam logic [2:0] PDS_GPIO6 = 3'h4;
  localparam logic [7:0] INST_DF_ON = 8'hfa;
  localparam logic [7:0] INST_DF_OFF = 8'hfb;
  localparam logic [7:0] INST_MODE_RD = 8'h9f;
  localparam int MODE_BIT = 1;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] RESET_KEY = 8'hc3;
  localparam int CLK_NS = 50;
  localparam int PWR_LAT_NS = 15000;
  localparam int PWR_LAT_CYC = (PWR_LAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 4;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_DOWN = 2'b01,
    PWR_STANDBY = 2'b11
  } sah_pwr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD = 2'b01,
    ST_SEND = 2'b10
  } sah_ph_t;

  typedef struct packed {
    logic [2:0] pin_driver_select;
    logic ready_to_gpio6;
    logic [6:0] data_only_start_addr;
    logic [2:0] data_only_byte_count;
    logic checksum_enable;
    logic ready_release_after_checksum;
    logic checksum_hold_over;
    logic clear_cal_coeffs;
    logic cal_mode_active;
  } sah_cfg_t;
endpackage : sah_pkg

// ===== testbench.sv
// Self-checking bench for the serial handshake block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int TIMEOUT_CYC = 20000;
  logic core_clk, nrst, sclk, cs_n, sdi, sdo_out, sdo_oe, sdo_pin;
  sah_pkg::sah_cfg_t cfg;
  logic gp_out, gp_oe, ready_raw_n, data_ready_n, bit_v, bit_d, bit_crc;
  logic ck_done, df_mode, pwr_wr, conv_en, key_wr, rst_wr;
  logic reg_rst, cal_rst, restart;
  logic [6:0] rd_addr;
  logic [7:0] rd_data, ck_val, key;
  logic [1:0] pwr_req, pwr_st;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc_cnt = 0;

  function automatic logic [7:0] reg_val(input logic [6:0] a);
    return {1'b1, a} ^ 8'h3c;
  endfunction : reg_val

  // Board pull-up holds the pin while undriven
  assign sdo_pin = sdo_oe ? sdo_out : 1'b1;
  assign rd_data = reg_val(rd_addr);

  sah_master m_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_pin));
  sah_handshake dut_u (.core_clk(core_clk), .nrst(nrst), .cfg(cfg),
    .sclk_in(sclk), .chip_select_n(cs_n), .sdi_in(sdi),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .gpio_pin_six_out(gp_out),
    .gpio_pin_six_oe(gp_oe), .ready_raw_n(ready_raw_n),
    .data_ready_n(data_ready_n), .rd_addr(rd_addr), .rd_data(rd_data),
    .ext_bit_valid(bit_v), .ext_bit(bit_d), .ext_bit_is_crc(bit_crc),
    .checksum_read_done(ck_done), .checksum_value(ck_val),
    .data_first_mode(df_mode), .pwr_wr(pwr_wr), .pwr_req(pwr_req),
    .power_state(pwr_st), .conv_enable(conv_en), .key_wr(key_wr),
    .soft_reset_key(key), .restart_wr(rst_wr),
    .reg_reset_pulse(reg_rst), .cal_reset_pulse(cal_rst),
    .conv_restart(restart));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == TIMEOUT_CYC) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic test_routing();
    // Bench holds a single slave, so ready may own SDO while deselected
    cfg.pin_driver_select = sah_pkg::PDS_CSB_FREE;
    for (int r = 0; r < 2; r++) begin
      ready_raw_n = r[0];
      tick(2);
      check(sdo_oe, 1'b1);
      check(sdo_out, r[0]);
    end
    cfg.pin_driver_select = sah_pkg::PDS_GPIO6;
    cfg.ready_to_gpio6 = 1'b1;
    ready_raw_n = 1'b0;
    tick(2);
    check(gp_oe, 1'b1);
    check(gp_out, 1'b0);
    check(sdo_oe, 1'b0);
    cfg = '0;
    tick(2);
    $display("routing test done");
  endtask : test_routing

  task automatic test_data_first();
    logic [7:0] rx;
    logic [6:0] a;
    m_u.open_frame();
    m_u.xfer(sah_pkg::INST_DF_ON, rx);
    m_u.close_frame();
    check(df_mode, 1'b1);
    tick(1);
    cfg.data_only_start_addr = 7'h7f;
    cfg.data_only_byte_count = 3'h2;
    for (int f = 0; f < 2; f++) begin
      a = 7'h7f;
      m_u.open_frame();
      for (int b = 0; b < 3; b++) begin
        m_u.xfer(8'hff, rx);
        check(rx, reg_val(a));
        a++;
      end
      m_u.xfer(f == 0 ? sah_pkg::INST_MODE_RD : sah_pkg::INST_DF_OFF, rx);
      if (f == 0) begin
        m_u.xfer(8'h00, rx);
        check(rx[sah_pkg::MODE_BIT], 1'b1);
      end
      m_u.close_frame();
    end
    check(df_mode, 1'b0);
    m_u.open_frame();
    m_u.xfer(sah_pkg::INST_MODE_RD, rx);
    m_u.xfer(8'h00, rx);
    check(rx[sah_pkg::MODE_BIT], 1'b0);
    m_u.close_frame();
    $display("data first test done");
  endtask : test_data_first

  function automatic logic [7:0] crc_of(input logic [7:0] c0,
    input logic [7:0] v);
    logic [7:0] c;
    c = c0;
    for (int i = 7; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h31 : 8'h00);
    end
    return c;
  endfunction : crc_of

  task automatic feed(input logic [7:0] v, input logic is_crc);
    for (int i = 7; i >= 0; i--) begin
      bit_v = 1'b1;
      bit_d = v[i];
      bit_crc = is_crc;
      tick(1);
    end
    bit_v = 1'b0;
    tick(2);
  endtask : feed

  task automatic test_crc();
    tick(1);
    cfg.checksum_enable = 1'b1;
    ready_raw_n = 1'b0;
    tick(2);
    check(ck_val, 8'hff);
    feed(8'ha5, 1'b0);
    check(ck_val, ~crc_of(8'h00, 8'ha5));
    feed(crc_of(8'h00, 8'ha5), 1'b1);
    check(ck_val, ~crc_of(8'h00, 8'ha5));
    ready_raw_n = 1'b1;
    tick(2);
    check(ck_val, 8'hff);
    feed(8'h5a, 1'b0);
    m_u.open_frame();
    m_u.close_frame();
    check(ck_val, 8'hff);
    ready_raw_n = 1'b0;
    cfg.checksum_hold_over = 1'b1;
    tick(1);
    feed(8'h3c, 1'b0);
    ready_raw_n = 1'b1;
    tick(2);
    check(ck_val, ~crc_of(8'h00, 8'h3c));
    cfg.checksum_hold_over = 1'b0;
    cfg.ready_release_after_checksum = 1'b1;
    ready_raw_n = 1'b0;
    tick(2);
    check(data_ready_n, 1'b0);
    ck_done = 1'b1;
    tick(1);
    ck_done = 1'b0;
    tick(1);
    check(data_ready_n, 1'b1);
    ready_raw_n = 1'b1;
    tick(2);
    ready_raw_n = 1'b0;
    tick(2);
    check(data_ready_n, 1'b0);
    cfg = '0;
    ready_raw_n = 1'b1;
    $display("checksum test done");
  endtask : test_crc

  task automatic pwr_pulse(input logic [1:0] req);
    pwr_req = req;
    pwr_wr = 1'b1;
    tick(1);
    pwr_wr = 1'b0;
    tick(1);
  endtask : pwr_pulse

  task automatic key_pulse(input logic [7:0] k, input logic er, input logic ec);
    key = k;
    key_wr = 1'b1;
    tick(1);
    key_wr = 1'b0;
    check(reg_rst, er);
    check(cal_rst, ec);
    tick(1);
    check(reg_rst, 1'b0);
  endtask : key_pulse

  task automatic test_power();
    // Unused code must neither move the state nor start the settle time
    pwr_pulse(2'h2);
    pwr_pulse(2'h1);
    check(conv_en, 1'b0);
    // Early request while settling is dropped
    pwr_pulse(2'h0);
    check(conv_en, 1'b0);
    tick(280);
    check(pwr_st, 2'h0);
    tick(30);
    check(pwr_st, 2'h1);
    pwr_pulse(2'h3);
    tick(320);
    check(pwr_st, 2'h1);
    key_pulse(8'h3c, 1'b0, 1'b0);
    key_pulse(sah_pkg::RESET_KEY, 1'b1, 1'b0);
    tick(310);
    check(pwr_st, 2'h0);
    check(conv_en, 1'b1);
    rst_wr = 1'b1;
    tick(1);
    rst_wr = 1'b0;
    check(restart, 1'b1);
    tick(1);
    check(restart, 1'b0);
    cfg.cal_mode_active = 1'b1;
    cfg.clear_cal_coeffs = 1'b1;
    tick(1);
    key_pulse(sah_pkg::RESET_KEY, 1'b0, 1'b0);
    key_pulse(sah_pkg::RESET_KEY, 1'b1, 1'b1);
    cfg = '0;
    $display("power and reset test done");
  endtask : test_power

  task automatic test_fifo();
    logic [7:0] rx, c;
    logic [6:0] a;
    m_u.open_frame();
    m_u.xfer(sah_pkg::INST_DF_ON, rx);
    m_u.close_frame();
    cfg.data_only_start_addr = 7'h20;
    cfg.data_only_byte_count = 3'h7;
    cfg.checksum_enable = 1'b1;
    tick(1);
    m_u.open_frame();
    // Four buffered words plus one in the shifter stall the fetch
    check(rd_addr, 7'h25);
    a = 7'h20;
    c = 8'h00;
    for (int b = 0; b < 8; b++) begin
      m_u.xfer(8'hff, rx);
      check(rx, reg_val(a));
      c = crc_of(c, reg_val(a));
      a++;
    end
    m_u.xfer(sah_pkg::INST_DF_OFF, rx);
    check(ck_val, ~c);
    m_u.close_frame();
    check(df_mode, 1'b0);
    check(rd_addr, 7'h28);
    cfg = '0;
    $display("buffer test done");
  endtask : test_fifo

  initial begin
    nrst = 1'b0;
    cfg = '0;
    ready_raw_n = 1'b1;
    {bit_v, bit_d, bit_crc, ck_done, pwr_wr, key_wr, rst_wr} = 7'h00;
    pwr_req = 2'h0;
    key = 8'h00;
    tick(8);
    nrst = 1'b1;
    tick(4);
    test_routing();
    test_data_first();
    test_crc();
    test_power();
    test_fifo();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
